// ---- hdl/irx_pkg.sv ----
/*
 * package for the isochronous receive interrupt event/mask block:
 * register offsets, field layout, reset values and bus carriers.
 * assumes a classic wishbone slave with 32-bit data and byte addresses.
 */
package irx_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_CHAN      = 4;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_EVENT_SET  = 8'ha0;
    localparam logic [7:0] OFF_EVENT_CLR  = 8'ha4;
    localparam logic [7:0] OFF_MASK_SET   = 8'ha8;
    localparam logic [7:0] OFF_MASK_CLR   = 8'hac;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned CHAN_LSB       = 0;
    localparam int unsigned SUMMARY_BIT    = 7;
    localparam logic [3:0]  EVENT_RST      = 4'h0;
    localparam logic [3:0]  MASK_RST       = 4'h0;
    localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } irx_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } irx_wb_rsp_s;

    // decoded single-cycle register write
    typedef struct packed {
        logic       ev_set;
        logic       ev_clr;
        logic       mk_set;
        logic       mk_clr;
        logic [3:0] bits;
    } irx_wr_s;

endpackage

// ---- hdl/irx_edge_detect.sv ----
/*
 * rising edge detector for the per-channel context interrupt lines.
 * assumes the lines are synchronous to clk_i.
 */
`timescale 1ns/1ps
module irx_edge_detect #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] level_i,
    output logic      [WIDTH-1:0] rise_o
);

    logic [WIDTH-1:0] prev_q;

    always_ff @(posedge clk_i) begin
        // a line held high through reset is no fresh edge
        if (rst_i) begin
            prev_q <= level_i;
        end else begin
            prev_q <= level_i;
        end
    end

    assign rise_o = level_i & ~prev_q;

endmodule

// ---- hdl/irx_wb_decode.sv ----
/*
 * wishbone classic write decoder: turns an accepted write into
 * one-cycle set/clear strobes for the event and mask registers.
 * assumes a classic master holding the request until ack.
 */
`timescale 1ns/1ps
module irx_wb_decode (
    input  wire irx_pkg::irx_wb_req_s req_i,
    input  wire logic                 take_i,
    output irx_pkg::irx_wr_s          wr_o
);

    logic wr_ok;

    // only byte lane 0 carries the channel bits
    assign wr_ok = take_i & req_i.we & req_i.sel[0];

    always_comb begin
        wr_o        = '0;
        wr_o.bits   = req_i.dat[3:0];
        if (req_i.adr == irx_pkg::OFF_EVENT_SET) begin
            wr_o.ev_set = wr_ok;
        end else if (req_i.adr == irx_pkg::OFF_EVENT_CLR) begin
            wr_o.ev_clr = wr_ok;
        end else if (req_i.adr == irx_pkg::OFF_MASK_SET) begin
            wr_o.mk_set = wr_ok;
        end else if (req_i.adr == irx_pkg::OFF_MASK_CLR) begin
            wr_o.mk_clr = wr_ok;
        end
    end

endmodule

// ---- hdl/irx_int_regs.sv ----
/*
 * isochronous receive interrupt event and mask registers with a
 * wishbone classic slave and the summary flag toward the main
 * interrupt event register.
 * assumes one clock, synchronous active-high reset, and context
 * interrupt lines synchronous to clk_i.
 */
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps

// Function
// - completed input descriptor with interrupt bits raises channel event.
// - event bit sets on line rising edge or write 1 at set address.
// - event bit clears only by write 1 at clear address.
// - clear-address read returns events AND mask.
// - event bits above channel bits read zero.
// - event bit n names channel n as summary bit 7 cause.
// - mask bit n gates event bit n toward summary.
// - mask reads at both addresses; write 1 sets or clears mask.
// - upper 28 bits zero after reset.
module irx_int_regs #(
    parameter int unsigned NUM_CHAN = irx_pkg::NUM_CHAN
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic                      wb_ack_o,
    output logic [31:0]               wb_dat_o,
    input  wire logic [NUM_CHAN-1:0]  ctx_irq_i,
    output logic [NUM_CHAN-1:0]       rx_event_o,
    output logic                      rx_summary_flag_o
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (NUM_CHAN != 4) begin : g_bad_chan
        $error("irx_int_regs supports exactly four channels");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    irx_pkg::irx_wb_req_s req;
    irx_pkg::irx_wr_s     wr;
    logic                 take;
    logic [3:0]           rise;
    logic [3:0]           event_q;
    logic [3:0]           event_d;
    logic [3:0]           mask_q;
    logic [3:0]           mask_d;
    logic                 ack_q;
    logic [31:0]          rdat_q;
    logic [31:0]          rdat_d;
    logic                 summary_q;

    function automatic logic [31:0] widen(input logic [3:0] v);
        widen = {28'h000_0000, v};
    endfunction

    // ------------------------------------------------------------
    // bus request
    // ------------------------------------------------------------
    assign req  = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                    sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
    // ack drops the cycle after it is given, even if stb stays up
    assign take = wb_cyc_i & wb_stb_i & ~ack_q;

    irx_wb_decode u_dec (
        .req_i  (req),
        .take_i (take),
        .wr_o   (wr)
    );

    irx_edge_detect #(.WIDTH(4)) u_edge (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i (ctx_irq_i),
        .rise_o  (rise)
    );

    // ------------------------------------------------------------
    // event register
    // ------------------------------------------------------------
    always_comb begin
        event_d = event_q;
        if (wr.ev_clr) begin
            event_d = event_d & ~wr.bits;
        end
        // edge or write-one set; set beats clear
        event_d = event_d | rise;
        if (wr.ev_set) begin
            event_d = event_d | wr.bits;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_q <= irx_pkg::EVENT_RST;
        end else begin
            event_q <= event_d;
        end
    end

    // ------------------------------------------------------------
    // mask register
    // ------------------------------------------------------------
    always_comb begin
        mask_d = mask_q;
        if (wr.mk_clr) begin
            mask_d = mask_d & ~wr.bits;
        end
        if (wr.mk_set) begin
            mask_d = mask_d | wr.bits;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= irx_pkg::MASK_RST;
        end else begin
            mask_q <= mask_d;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        if (wb_adr_i == irx_pkg::OFF_EVENT_SET) begin
            rdat_d = widen(event_q);
        end else if (wb_adr_i == irx_pkg::OFF_EVENT_CLR) begin
            rdat_d = widen(event_q & mask_q);
        end else if (wb_adr_i == irx_pkg::OFF_MASK_SET ||
                     wb_adr_i == irx_pkg::OFF_MASK_CLR) begin
            rdat_d = widen(mask_q);
        end else begin
            rdat_d = irx_pkg::UNMAPPED_DATA;
        end
    end

    // unmapped addresses still ack, reading zero, so no bus hang
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= take;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (take && !wb_we_i) begin
            rdat_q <= rdat_d;
        end
    end

    // ------------------------------------------------------------
    // summary flag
    // ------------------------------------------------------------
    // masked event or-reduce
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            summary_q <= 1'b0;
        end else begin
            summary_q <= |(event_d & mask_d);
        end
    end

    assign rx_event_o        = event_q;
    assign rx_summary_flag_o = summary_q;
    assign wb_ack_o          = ack_q;
    assign wb_dat_o          = rdat_q;

endmodule

// ---- verification/irx_asserts.sv ----
/* checker for the receive interrupt event and mask registers.
 * assumes it is bound to irx_int_regs and sees only its ports. */
`timescale 1ns/1ps
module irx_asserts #(
    parameter int unsigned NUM_CHAN = 4
) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [3:0]          wb_sel_i,
    input wire logic [7:0]          wb_adr_i,
    input wire logic [31:0]         wb_dat_i,
    input wire logic                wb_ack_o,
    input wire logic [31:0]         wb_dat_o,
    input wire logic [NUM_CHAN-1:0] ctx_irq_i,
    input wire logic [NUM_CHAN-1:0] rx_event_o,
    input wire logic                rx_summary_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [NUM_CHAN-1:0] prev_q;
    logic [NUM_CHAN-1:0] rise;
    logic                take, clr_w, cause, rd_raw, rd_and;
    logic [NUM_CHAN-1:0] mk_q;
    // no reset: edge history must survive a reset pulse
    always_ff @(posedge clk_i) prev_q <= ctx_irq_i;
    assign rise   = ctx_irq_i & ~prev_q;
    assign take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign clr_w  = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'ha4);
    assign cause  = (take & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'ha0)) | (|rise);
    assign rd_raw = take & ~wb_we_i & (wb_adr_i == 8'ha0);
    assign rd_and = take & ~wb_we_i & (wb_adr_i == 8'ha4);
    // mask shadow kept from bus writes, zero after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mk_q <= '0;
        end else if (take & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'ha8)) begin
            mk_q <= mk_q | wb_dat_i[NUM_CHAN-1:0];
        end else if (take & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'hac)) begin
            mk_q <= mk_q & ~wb_dat_i[NUM_CHAN-1:0];
        end
    end

    ack_latency_a: assert property (take |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    rsvd_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:4] == 28'h0)
        else $error("reserved read bits not zero");
    raw_read_a: assert property (!$past(rst_i) && $past(rd_raw)
        |-> wb_dat_o[3:0] == $past(rx_event_o)) else $error("set address read not raw");
    and_read_a: assert property (!$past(rst_i) && $past(rd_and)
        |-> wb_dat_o[3:0] == ($past(rx_event_o) & $past(mk_q)))
        else $error("clear read not masked");
    edge_set_a: assert property (rise != 0
        |=> (rx_event_o & $past(rise)) == $past(rise)) else $error("edge did not set event");
    clr_only_a: assert property (!$past(rst_i) && (~rx_event_o & $past(rx_event_o)) != 0
        |-> $past(clr_w)) else $error("event cleared without clear write");
    set_cause_a: assert property (!$past(rst_i) && (rx_event_o & ~$past(rx_event_o)) != 0
        |-> $past(cause)) else $error("event set without cause");
    summary_src_a: assert property (rx_summary_flag_o |-> rx_event_o != 0)
        else $error("summary without event");
    summary_mask_a: assert property (rx_summary_flag_o == |(rx_event_o & mk_q))
        else $error("summary not gated by mask");
endmodule

bind irx_int_regs irx_asserts #(.NUM_CHAN(NUM_CHAN)) u_irx_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .ctx_irq_i(ctx_irq_i),
    .rx_event_o(rx_event_o), .rx_summary_flag_o(rx_summary_flag_o));

// ---- verification/irx_ctx_model.sv ----
/* model of the receive dma contexts driving their interrupt lines.
 * assumes the bench calls complete() from its own sequence. */
`timescale 1ns/1ps
module irx_ctx_model (
    input  wire logic       clk_i,
    output logic      [3:0] ctx_irq_o
);
    initial ctx_irq_o = 4'h0;
    task automatic complete(input int n, input int hold);
        @(posedge clk_i);
        ctx_irq_o[n] <= 1'b1;
        repeat (hold) @(posedge clk_i);
        ctx_irq_o[n] <= 1'b0;
    endtask
endmodule

// ---- verification/tb_top.sv ----
/* self-checking bench for irx_int_regs.
 * assumes a one-wait classic slave and the context model. */
`timescale 1ns/1ps
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        we    = 1'b0;
    logic [3:0]  sel   = 4'h0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0;
    logic [31:0] rdat, d;
    logic        ack, sum;
    logic [3:0]  ctx, ev_o, ev, mk;
    logic [31:0] exp_q[$];
    logic [7:0]  offs[5] = '{8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hb0};
    int          fail_count = 0;
    int          n_tests = 0;
    always #25 clk_i = ~clk_i;
    irx_int_regs u_irx_int_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_ack_o(ack), .wb_dat_o(rdat), .ctx_irq_i(ctx), .rx_event_o(ev_o),
        .rx_summary_flag_o(sum));
    irx_ctx_model u_irx_ctx_model (.clk_i(clk_i), .ctx_irq_o(ctx));
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] v,
                      input logic [3:0] s);
        @(posedge clk_i);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= v;
        sel  <= s;
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [3:0] e);
        exp_q.push_back({28'h0, e});
        wb(a, 1'b0, 32'h0, 4'hf);
    endtask
    // one idle edge also gives the bus its gap
    task automatic look;
        @(posedge clk_i);
        chk({28'h0, ev_o}, {28'h0, ev});
        chk({31'h0, sum}, {31'h0, |(ev & mk)});
    endtask
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) chk(rdat, exp_q.pop_front());
    end
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk_i);
        fail_count++;
        finish_test();
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h27c8594e));
        ev = 4'h0;
        mk = 4'h0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (offs[i]) rd(offs[i], 4'h0);
        repeat (6) begin
            d = $urandom();
            wb(8'ha0, 1'b1, d, 4'hf);
            ev = ev | d[3:0];
            wb(8'ha4, 1'b1, {d[31:4], 4'h0}, 4'hf);
            d = $urandom();
            wb(8'ha8, 1'b1, d, 4'hf);
            mk = mk | d[3:0];
            rd(8'ha0, ev);
            rd(8'ha4, ev & mk);
            rd(8'ha8, mk);
            rd(8'hac, mk);
            look;
            d = $urandom();
            wb(8'hac, 1'b1, d, 4'hf);
            mk = mk & ~d[3:0];
            d = $urandom();
            wb(8'ha4, 1'b1, d, 4'hf);
            ev = ev & ~d[3:0];
            look;
        end
        // ignored writes: no byte 0 enable, unmapped place
        wb(8'ha0, 1'b1, 32'hf, 4'he);
        wb(8'hb0, 1'b1, 32'hf, 4'hf);
        rd(8'ha0, ev);
        wb(8'ha8, 1'b1, 32'hf, 4'hf);
        mk = 4'hf;
        for (int n = 0; n < 4; n++) begin
            wb(8'ha4, 1'b1, 32'hf, 4'hf);
            ev = 4'h0;
            u_irx_ctx_model.complete(n, n + 1);
            ev[n] = 1'b1;
            look;
            rd(8'ha0, ev);
        end
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        ev = 4'h0;
        mk = 4'h0;
        look;
        finish_test();
    end
endmodule
